// ===== core/ext_bus_pkg.sv
/*
  Shared constants and types of the external memory bus interface: request
  kinds, sequencer states, cycle lengths and port latch reset values.
  Assumes one oscillator period equals one period of the 50 MHz clock mclk.
*/
package ext_bus_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned OSC_PERIOD_NS    = 20;
  // Oscillator periods per bus cycle, turned into mclk cycles.
  localparam int unsigned FETCH_OSC_PERIODS = 3;
  localparam int unsigned DATA_OSC_PERIODS  = 6;
  localparam int unsigned FETCH_CYCLES = (FETCH_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_CYCLES  = (DATA_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] FETCH_LAST_PHASE = 3'(FETCH_CYCLES - 1);
  localparam logic [2:0] DATA_LAST_PHASE  = 3'(DATA_CYCLES - 1);

  // Phase positions inside a cycle.
  localparam logic [2:0] PH_ADDR        = 3'h0;
  localparam logic [2:0] PH_FETCH_SAMPLE = 3'h2;
  localparam logic [2:0] PH_RD_FIRST    = 3'h2;
  localparam logic [2:0] PH_RD_SAMPLE   = 3'h4;
  localparam logic [2:0] PH_WR_DATA     = 3'h2;
  localparam logic [2:0] PH_WR_FIRST    = 3'h3;
  localparam logic [2:0] PH_WR_LAST     = 3'h4;

  // ************************************************************
  // Reset values and pin positions
  // ************************************************************
  localparam logic [7:0] LOW_PORT_RESET   = 8'hFF;
  localparam logic [7:0] HIGH_PORT_RESET  = 8'hFF;
  localparam logic [7:0] LOW_PORT_BUS_FILL = 8'hFF;
  localparam logic       STROBE_ENABLE_RESET = 1'b1;
  localparam int unsigned P3_READ_STROBE_BIT  = 7;
  localparam int unsigned P3_WRITE_STROBE_BIT = 6;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    KIND_INT_FETCH  = 2'b00,
    KIND_EXT_FETCH  = 2'b01,
    KIND_DATA_READ  = 2'b10,
    KIND_DATA_WRITE = 2'b11
  } req_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_INT_FETCH = 3'b001,
    ST_EXT_FETCH = 3'b010,
    ST_READ      = 3'b011,
    ST_WRITE     = 3'b100
  } bus_state_t;

endpackage

// ===== core/port_latch_pair.sv
/*
  The two port latches behind the low (multiplexed) and high address ports.
  Assumes the core writes them with one-cycle strobes and that the bus
  sequencer signals the start of each external access with a pulse.
*/
`timescale 1ns/1ps
module port_latch_pair
  import ext_bus_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       lowLatchWe,
  input  wire logic       highLatchWe,
  input  wire logic [7:0] latchWdata,
  input  wire logic       busAccessStart,
  output logic      [7:0] lowLatch,
  output logic      [7:0] highLatch
);

  // ************************************************************
  // Next values
  // ************************************************************
  logic [7:0] next_lowLatch;
  logic [7:0] next_highLatch;

  // A bus access fills the low latch with ones and wins over a core write.
  always_comb begin
    next_lowLatch  = lowLatch;
    next_highLatch = highLatch;
    if (busAccessStart) begin
      next_lowLatch = LOW_PORT_BUS_FILL;
    end else if (lowLatchWe) begin
      next_lowLatch = latchWdata;
    end
    // The high latch only follows core writes, never the bus.
    if (highLatchWe) begin
      next_highLatch = latchWdata;
    end
  end

  // Registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lowLatch  <= LOW_PORT_RESET;
      highLatch <= HIGH_PORT_RESET;
    end else begin
      lowLatch  <= next_lowLatch;
      highLatch <= next_highLatch;
    end
  end

endmodule

// ===== core/external_memory_bus_interface.sv
/*
  Sequencer of the external memory bus: program fetches, data reads and data
  writes over the multiplexed low port and the high address port, with the
  program fetch, data read, data write and address latch strobes.
  Assumes requests come from the core synchronous to mclk and that the pads
  resolve each pin from its output and output enable.
*/
`timescale 1ns/1ps
module external_memory_bus_interface
  import ext_bus_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  // Core request side.
  input  wire logic        reqValid,
  input  wire logic [1:0]  reqKind,
  input  wire logic [15:0] reqAddr,
  input  wire logic        reqWide,
  input  wire logic [7:0]  reqWdata,
  output logic             reqReady,
  output logic             rspValid,
  output logic [7:0]       rspData,
  // Core access to the port latches and the control bit.
  input  wire logic        lowLatchWe,
  input  wire logic        highLatchWe,
  input  wire logic [7:0]  latchWdata,
  input  wire logic        controlWe,
  input  wire logic        controlWdata,
  output logic             latchStrobeOutputEnable,
  output logic [7:0]       lowLatchValue,
  output logic [7:0]       highLatchValue,
  // Pins.
  input  wire logic        externalAccessSelectN,
  input  wire logic [7:0]  multiplexedLowPortIn,
  output logic [7:0]       multiplexedLowPortOut,
  output logic [7:0]       multiplexedLowPortOe,
  output logic [7:0]       highAddressPortOut,
  output logic [7:0]       highAddressPortOe,
  output logic             addressLatchStrobe,
  output logic             programFetchStrobeN,
  output logic             dataReadStrobeN,
  output logic             dataWriteStrobeN
);

  // ************************************************************
  // Port latches
  // ************************************************************
  logic [7:0] lowLatch;
  logic [7:0] highLatch;
  logic       busAccessStart;

  port_latch_pair u_latches (
    .mclk           (mclk),
    .rst            (rst),
    .lowLatchWe     (lowLatchWe),
    .highLatchWe    (highLatchWe),
    .latchWdata     (latchWdata),
    .busAccessStart (busAccessStart),
    .lowLatch       (lowLatch),
    .highLatch      (highLatch)
  );

  assign lowLatchValue  = lowLatch;
  assign highLatchValue = highLatch;

  // ************************************************************
  // Sequencer state
  // ************************************************************
  bus_state_t  state;
  bus_state_t  next_state;
  logic [2:0]  phase;
  logic [2:0]  next_phase;
  logic [15:0] curAddr;
  logic [15:0] next_curAddr;
  logic        curWide;
  logic        next_curWide;
  logic [7:0]  curWdata;
  logic [7:0]  next_curWdata;
  logic        next_latchStrobeOutputEnable;
  logic        next_reqReady;
  logic        next_rspValid;
  logic [7:0]  next_rspData;
  logic [7:0]  next_lowOut;
  logic [7:0]  next_lowOe;
  logic [7:0]  next_highOut;
  logic [7:0]  next_highOe;
  logic        next_ale;
  logic        next_fetchN;
  logic        next_readN;
  logic        next_writeN;

  // Last phase of a cycle of the given kind.
  function automatic logic [2:0] last_phase(input bus_state_t s);
    if (s == ST_READ || s == ST_WRITE) begin
      last_phase = DATA_LAST_PHASE;
    end else begin
      last_phase = FETCH_LAST_PHASE;
    end
  endfunction

  // True when a phase lies inside an inclusive window.
  function automatic logic in_window(input logic [2:0] p, input logic [2:0] lo, input logic [2:0] hi);
    in_window = (p >= lo) && (p <= hi);
  endfunction

  // Next state and captured request. A new request is taken only in idle,
  // so outputs can be derived from the next state without a bubble.
  always_comb begin
    next_state     = state;
    next_phase     = phase;
    next_curAddr   = curAddr;
    next_curWide   = curWide;
    next_curWdata  = curWdata;
    busAccessStart = 1'b0;
    next_rspValid  = 1'b0;
    next_rspData   = rspData;
    next_latchStrobeOutputEnable = latchStrobeOutputEnable;
    if (controlWe) begin
      next_latchStrobeOutputEnable = controlWdata;
    end
    case (state)
      ST_IDLE: begin
        if (reqValid) begin
          next_phase    = PH_ADDR;
          next_curAddr  = reqAddr;
          next_curWdata = reqWdata;
          case (req_kind_t'(reqKind))
            KIND_INT_FETCH: begin
              next_state   = ST_INT_FETCH;
              next_curWide = 1'b1;
            end
            KIND_EXT_FETCH: begin
              next_state   = ST_EXT_FETCH;
              next_curWide = 1'b1;
            end
            KIND_DATA_READ: begin
              next_state   = ST_READ;
              next_curWide = reqWide;
            end
            default: begin
              next_state   = ST_WRITE;
              next_curWide = reqWide;
            end
          endcase
          // Internal fetches never touch the bus, so they leave the latch alone.
          busAccessStart = (req_kind_t'(reqKind) != KIND_INT_FETCH);
        end
      end
      default: begin
        if (phase == last_phase(state)) begin
          next_state = ST_IDLE;
          next_phase = PH_ADDR;
        end else begin
          next_phase = phase + 3'h1;
        end
      end
    endcase
    // Read data is sampled while the strobe is still active, at the edge
    // that releases it.
    if ((state == ST_EXT_FETCH && phase == PH_FETCH_SAMPLE) || (state == ST_READ && phase == PH_RD_SAMPLE)) begin
      next_rspData = multiplexedLowPortIn;
    end
    if ((state != ST_IDLE) && (phase == last_phase(state))) begin
      next_rspValid = 1'b1;
    end
  end

  // ************************************************************
  // Pin values
  // ************************************************************
  // Pin levels follow the next state so every pin comes from a flip-flop.
  always_comb begin
    next_reqReady = (next_state == ST_IDLE);
    next_ale      = 1'b0;
    next_fetchN   = 1'b1;
    next_readN    = 1'b1;
    next_writeN   = 1'b1;
    // Outside bus cycles the low port is an open-drain port: only zeros pull.
    next_lowOut   = 8'h00;
    next_lowOe    = ~lowLatch;
    next_highOut  = highLatch;
    next_highOe   = 8'hFF;
    case (next_state)
      ST_INT_FETCH: begin
        // Code from internal memory pulses the latch strobe only when allowed.
        next_ale = (next_phase == PH_ADDR) && (latchStrobeOutputEnable || !externalAccessSelectN);
      end
      ST_EXT_FETCH: begin
        next_ale    = (next_phase == PH_ADDR);
        next_fetchN = (next_phase == PH_ADDR);
        next_highOut = next_curAddr[15:8];
        if (next_phase == PH_ADDR) begin
          next_lowOut = next_curAddr[7:0];
          next_lowOe  = 8'hFF;
        end else begin
          next_lowOe = 8'h00;
        end
      end
      ST_READ, ST_WRITE: begin
        // Data moves always strobe the latch, whatever the enable bit says.
        next_ale = (next_phase == PH_ADDR);
        // The high port is driven for the whole cycle, so ones keep the
        // strong pull-up throughout instead of a short boost.
        next_highOut = next_curWide ? next_curAddr[15:8] : highLatch;
        next_lowOe   = 8'hFF;
        if (next_phase < PH_WR_DATA) begin
          next_lowOut = next_curAddr[7:0];
        end else if (next_state == ST_WRITE) begin
          next_lowOut = next_curWdata;
        end else begin
          next_lowOe = 8'h00;
        end
        if (next_state == ST_READ) begin
          next_readN = !in_window(next_phase, PH_RD_FIRST, PH_RD_SAMPLE);
        end else begin
          // Data is out one phase before the strobe and one phase after it.
          next_writeN = !in_window(next_phase, PH_WR_FIRST, PH_WR_LAST);
        end
      end
      default: begin
        next_ale = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // All state and pin registers; strobes idle inactive from reset on.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state                   <= ST_IDLE;
      phase                   <= PH_ADDR;
      curAddr                 <= 16'h0000;
      curWide                 <= 1'b0;
      curWdata                <= 8'h00;
      latchStrobeOutputEnable <= STROBE_ENABLE_RESET;
      reqReady                <= 1'b0;
      rspValid                <= 1'b0;
      rspData                 <= 8'h00;
      multiplexedLowPortOut   <= 8'h00;
      multiplexedLowPortOe    <= 8'h00;
      highAddressPortOut      <= HIGH_PORT_RESET;
      highAddressPortOe       <= 8'hFF;
      addressLatchStrobe      <= 1'b0;
      programFetchStrobeN     <= 1'b1;
      dataReadStrobeN         <= 1'b1;
      dataWriteStrobeN        <= 1'b1;
    end else begin
      state                   <= next_state;
      phase                   <= next_phase;
      curAddr                 <= next_curAddr;
      curWide                 <= next_curWide;
      curWdata                <= next_curWdata;
      latchStrobeOutputEnable <= next_latchStrobeOutputEnable;
      reqReady                <= next_reqReady;
      rspValid                <= next_rspValid;
      rspData                 <= next_rspData;
      multiplexedLowPortOut   <= next_lowOut;
      multiplexedLowPortOe    <= next_lowOe;
      highAddressPortOut      <= next_highOut;
      highAddressPortOe       <= next_highOe;
      addressLatchStrobe      <= next_ale;
      programFetchStrobeN     <= next_fetchN;
      dataReadStrobeN         <= next_readN;
      dataWriteStrobeN        <= next_writeN;
    end
  end

endmodule

// ===== verification/ext_bus_monitor.sv
/*
  Checker of the external bus sequencer: strobe order, cycle lengths, address and data on the ports.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module ext_bus_monitor
  import ext_bus_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reqValid,
  input wire logic [1:0]  reqKind,
  input wire logic [15:0] reqAddr,
  input wire logic        reqWide,
  input wire logic [7:0]  reqWdata,
  input wire logic        reqReady,
  input wire logic        rspValid,
  input wire logic        latchStrobeOutputEnable,
  input wire logic [7:0]  lowLatchValue,
  input wire logic [7:0]  highLatchValue,
  input wire logic        externalAccessSelectN,
  input wire logic [7:0]  multiplexedLowPortOut,
  input wire logic [7:0]  multiplexedLowPortOe,
  input wire logic [7:0]  highAddressPortOut,
  input wire logic [7:0]  highAddressPortOe,
  input wire logic        addressLatchStrobe,
  input wire logic        programFetchStrobeN,
  input wire logic        dataReadStrobeN,
  input wire logic        dataWriteStrobeN
);
  // ****************************************
  // Helper logic and cycle shapes
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic       take;
  logic [7:0] hiHeld;
  logic [7:0] loHeld;
  logic [7:0] wdHeld;
  assign take = reqValid && reqReady;
  // The request fields are only valid at the take edge, so keep a copy.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hiHeld <= 8'h00;
      loHeld <= 8'h00;
      wdHeld <= 8'h00;
    end else if (take) begin
      hiHeld <= reqAddr[15:8];
      loHeld <= reqAddr[7:0];
      wdHeld <= reqWdata;
    end
  end
  sequence s_fetch;
    addressLatchStrobe && programFetchStrobeN ##1 !programFetchStrobeN [*2] ##1 programFetchStrobeN && rspValid;
  endsequence
  sequence s_read;
    addressLatchStrobe ##1 dataReadStrobeN ##1 !dataReadStrobeN [*3] ##1 dataReadStrobeN && !rspValid ##1 rspValid;
  endsequence
  sequence s_write;
    addressLatchStrobe ##1 dataWriteStrobeN [*2] ##1 !dataWriteStrobeN [*2] ##1 dataWriteStrobeN ##1 rspValid;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  property p_one_strobe;
    $countones({~programFetchStrobeN, ~dataReadStrobeN, ~dataWriteStrobeN}) <= 1;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two bus strobes active at once");
  property p_fetch_seq;
    take && reqKind == KIND_EXT_FETCH |=> s_fetch;
  endproperty
  a_fetch_seq: assert property (p_fetch_seq) else $error("fetch cycle shape wrong");
  property p_read_seq;
    take && reqKind == KIND_DATA_READ |=> s_read;
  endproperty
  a_read_seq: assert property (p_read_seq) else $error("read cycle shape wrong");
  property p_write_seq;
    take && reqKind == KIND_DATA_WRITE |=> s_write;
  endproperty
  a_write_seq: assert property (p_write_seq) else $error("write cycle shape wrong");
  property p_addr_out;
    take && reqKind != KIND_INT_FETCH |=> multiplexedLowPortOut == loHeld && multiplexedLowPortOe == 8'hFF
      && lowLatchValue == 8'hFF;
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("low address phase wrong");
  property p_wide_high;
    take && (reqKind == KIND_EXT_FETCH || reqKind[1] && reqWide) |=> (highAddressPortOut == hiHeld) [*3];
  endproperty
  a_wide_high: assert property (p_wide_high) else $error("high address byte not held");
  property p_wide_data_high;
    take && reqKind[1] && reqWide |=> (highAddressPortOut == hiHeld) [*6];
  endproperty
  a_wide_data_high: assert property (p_wide_data_high) else $error("high byte dropped in data cycle");
  property p_narrow_high;
    take && reqKind[1] && !reqWide |=> (highAddressPortOut == highLatchValue) [*6];
  endproperty
  a_narrow_high: assert property (p_narrow_high) else $error("high latch not on pins");
  property p_wr_setup;
    $fell(dataWriteStrobeN) |-> $past(multiplexedLowPortOe) == 8'hFF && $past(multiplexedLowPortOut) == wdHeld;
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("write data late");
  property p_wr_hold;
    $rose(dataWriteStrobeN) |-> multiplexedLowPortOe == 8'hFF && multiplexedLowPortOut == wdHeld;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data dropped early");
  property p_rd_release;
    !dataReadStrobeN |-> multiplexedLowPortOe == 8'h00;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("low port driven during read");
  property p_high_strong;
    highAddressPortOe == 8'hFF;
  endproperty
  a_high_strong: assert property (p_high_strong) else $error("high port not driven");
  property p_int_ale;
    take && reqKind == KIND_INT_FETCH |=> addressLatchStrobe == ($past(latchStrobeOutputEnable)
      || !$past(externalAccessSelectN));
  endproperty
  a_int_ale: assert property (p_int_ale) else $error("latch strobe gating wrong");
  property p_ale_reset;
    $fell(rst) |-> latchStrobeOutputEnable;
  endproperty
  a_ale_reset: assert property (p_ale_reset) else $error("strobe enable not set by reset");
endmodule
bind external_memory_bus_interface ext_bus_monitor u_mon (.mclk, .rst, .reqValid, .reqKind, .reqAddr, .reqWide,
  .reqWdata, .reqReady, .rspValid, .latchStrobeOutputEnable, .lowLatchValue, .highLatchValue,
  .externalAccessSelectN, .multiplexedLowPortOut, .multiplexedLowPortOe, .highAddressPortOut,
  .highAddressPortOe, .addressLatchStrobe, .programFetchStrobeN, .dataReadStrobeN, .dataWriteStrobeN);

// ===== verification/ext_mem_model.sv
/*
  Behavioural external memory shared by code and data, 256 bytes.
  Assumes the bench resolves the low port pins from both drivers.
*/
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic       mclk,
  input  wire logic       ale,
  input  wire logic       fetchN,
  input  wire logic       readN,
  input  wire logic       writeN,
  input  wire logic [7:0] lowOut,
  input  wire logic [7:0] highOut,
  input  wire logic [7:0] lowPins,
  output logic      [7:0] busIn
);
  logic [7:0]  mem [256];
  logic [15:0] addrQ = 16'h0000;
  logic [7:0]  lastQ = 8'h00;
  logic        drive;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
  // Released lines show the inverse of the last byte so a stale value never passes.
  assign drive = !fetchN || !readN;
  assign busIn = drive ? mem[addrQ[15:8] ^ addrQ[7:0]] : ~lastQ;
  // Address is latched on the strobe; writes land while the write strobe is low.
  always @(posedge mclk) begin
    if (ale) addrQ <= {highOut, lowOut};
    if (drive) lastQ <= busIn;
    if (!writeN) mem[addrQ[15:8] ^ addrQ[7:0]] <= lowPins;
  end
endmodule

// ===== verification/tb_external_memory_bus_interface.sv
/*
  Self-checking bench of the external bus sequencer with a memory on the bus.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module tb_external_memory_bus_interface;
  import ext_bus_pkg::*;
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic        reqValid = 1'h0;
  logic [1:0]  reqKind = 2'h0;
  logic [15:0] reqAddr = 16'h0000;
  logic        reqWide = 1'h0;
  logic [7:0]  reqWdata = 8'h00;
  logic        lowLatchWe = 1'h0;
  logic        highLatchWe = 1'h0;
  logic [7:0]  latchWdata = 8'h00;
  logic        controlWe = 1'h0;
  logic        controlWdata = 1'h0;
  logic        externalAccessSelectN = 1'h1;
  logic        reqReady, rspValid, latchStrobeOutputEnable, addressLatchStrobe;
  logic        programFetchStrobeN, dataReadStrobeN, dataWriteStrobeN;
  logic [7:0]  rspData, lowLatchValue, highLatchValue, busIn, multiplexedLowPortIn;
  logic [7:0]  multiplexedLowPortOut, multiplexedLowPortOe, highAddressPortOut, highAddressPortOe;
  logic [7:0]  shadow [256];
  logic [7:0]  hl = 8'hFF;
  logic        en = 1'h1;
  int          bad_count = 0;
  int          n_checks = 0;
  // About 120 requests and pokes; budget of 150, each waiting at most for two data cycles, doubled for margin.
  localparam int WATCHDOG_CYCLES = 150 * 4 * DATA_CYCLES;
  always #10 mclk = ~mclk;
  // Each pin shows the block where it drives, the memory elsewhere.
  assign multiplexedLowPortIn = (multiplexedLowPortOe & multiplexedLowPortOut) | (~multiplexedLowPortOe & busIn);
  external_memory_bus_interface u_dut (.mclk, .rst, .reqValid, .reqKind, .reqAddr, .reqWide, .reqWdata,
    .reqReady, .rspValid, .rspData, .lowLatchWe, .highLatchWe, .latchWdata, .controlWe, .controlWdata,
    .latchStrobeOutputEnable, .lowLatchValue, .highLatchValue, .externalAccessSelectN, .multiplexedLowPortIn,
    .multiplexedLowPortOut, .multiplexedLowPortOe, .highAddressPortOut, .highAddressPortOe,
    .addressLatchStrobe, .programFetchStrobeN, .dataReadStrobeN, .dataWriteStrobeN);
  ext_mem_model u_mem (.mclk, .ale(addressLatchStrobe), .fetchN(programFetchStrobeN), .readN(dataReadStrobeN),
    .writeN(dataWriteStrobeN), .lowOut(multiplexedLowPortOut), .highOut(highAddressPortOut),
    .lowPins(multiplexedLowPortIn), .busIn);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bounded wait until the block is idle, sampled away from the edge.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (reqReady !== 1'h1 && n < 20);
    chk("reqReady", reqReady, 1'h1);
  endtask
  // Memory cell that a request reaches: wide moves and external fetches use the address high byte, narrow ones the high latch.
  function automatic logic [7:0] cell_of(input logic [1:0] k, input logic [15:0] a, input logic w);
    cell_of = (k == 2'h1 || w) ? a[15:8] ^ a[7:0] : hl ^ a[7:0];
  endfunction
  // Bus cycles always pulse the latch strobe; internal fetches only when enabled or with select low.
  function automatic logic ale_of(input logic [1:0] k);
    ale_of = k != 2'h0 || en || !externalAccessSelectN;
  endfunction
  // Follows one cycle to its end; runs beside the next request.
  task automatic watch(input logic [1:0] k, input logic [7:0] e, input logic aleExp);
    @(negedge mclk);
    chk("ale", addressLatchStrobe, aleExp);
    repeat (k[1] ? 6 : 3) @(negedge mclk);
    chk("rspValid", rspValid, 1'h1);
    if (k == 2'h1 || k == 2'h2) chk("rspData", rspData, e);
    if (k != 2'h0) chk("lowLatch", lowLatchValue, 8'hFF);
    chk("highLatch", highLatchValue, hl);
  endtask
  // Request held until taken; returns at the take edge so the next one can follow at once.
  task automatic access(input logic [1:0] k, input logic [15:0] a, input logic w, input logic [7:0] d);
    logic [7:0] idx;
    logic [7:0] e;
    idx = cell_of(k, a, w);
    e = shadow[idx];
    if (k == 2'h3) shadow[idx] = d;
    @(posedge mclk);
    reqValid <= 1'h1;
    reqKind <= k;
    reqAddr <= a;
    reqWide <= w;
    reqWdata <= d;
    wait_idle();
    @(posedge mclk);
    reqValid <= 1'h0;
    fork
      watch(k, e, ale_of(k));
    join_none
  endtask
  // Latch or control write while idle: 0 low latch, 1 high latch, 2 control.
  task automatic poke(input int t, input logic [7:0] v);
    wait_idle();
    @(posedge mclk);
    lowLatchWe <= (t == 0);
    highLatchWe <= (t == 1);
    controlWe <= (t == 2);
    latchWdata <= v;
    controlWdata <= v[0];
    if (t == 2) externalAccessSelectN <= v[1];
    @(posedge mclk);
    lowLatchWe <= 1'h0;
    highLatchWe <= 1'h0;
    controlWe <= 1'h0;
    if (t == 1) hl = v;
    if (t == 2) en = v[0];
    @(negedge mclk);
    if (t == 0) chk("lowLatch", lowLatchValue, v);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    void'($urandom(22));
    for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 7 + 3);
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    chk("enable", latchStrobeOutputEnable, 1'h1);
    chk("highLatch", highLatchValue, 8'hFF);
    poke(0, 8'h5A);
    poke(1, 8'h3C);
    access(2'h2, 16'h1234, 1'h0, 8'h00);
    access(2'h3, 16'hFFFF, 1'h1, 8'hA5);
    access(2'h2, 16'hFFFF, 1'h1, 8'h00);
    access(2'h3, 16'h0000, 1'h0, 8'h01);
    access(2'h2, 16'h0000, 1'h0, 8'h00);
    // Every enable and select combination, each followed by an internal fetch, a data write and an external fetch.
    for (int i = 0; i < 4; i++) begin
      poke(2, 8'(i));
      access(2'h0, 16'h0100, 1'h0, 8'h00);
      access(2'h3, 16'h0042, 1'h0, 8'(i));
      access(2'h1, 16'h8000, 1'h0, 8'h00);
    end
    for (int i = 0; i < 80; i++) begin
      if ($urandom % 4 == 0) poke($urandom % 3, 8'($urandom));
      access(2'($urandom), 16'($urandom), 1'($urandom), 8'($urandom));
    end
    wait_idle();
    repeat (8) @(posedge mclk);
    results();
  end
  initial begin
    repeat (WATCHDOG_CYCLES) @(posedge mclk);
    bad_count++;
    results();
  end
endmodule
